//--- verilog/cao_map.svh
// Purpose: Offsets, field positions and reset values of the comparator block.
// Assumes: Included by the design file only.
// Notes: Byte addresses on a 32-bit APB bus.
`ifndef CAO_MAP_SVH
`define CAO_MAP_SVH
// Byte address of the control register.
`define CAO_CTRL_ADDR       12'hf90
// Field positions in the control register.
`define CAO_BIT_CMP_EN      0
`define CAO_BIT_CMP_OUT     1
`define CAO_BIT_FAULT_POL   2
`define CAO_BIT_IRQ_EDGE    3
`define CAO_BIT_IN_SEL      4
`define CAO_BIT_AMP_EN      7
// Reset value of every writable field.
`define CAO_CTRL_RESET      8'h00
// Full-scale code of the sampled analog levels.
`define CAO_CODE_MAX        10'h3ff
// Open-loop gain of the amplifier model.
`define CAO_AMP_GAIN        14'h2710
`endif

//--- verilog/cao_pkg.sv
// Purpose: Types shared by the comparator and amplifier control block.
// Assumes: Analog levels arrive as 10-bit sampled codes.
// Notes: Constants live in cao_map.svh.
package cao_pkg;
   // One sampled analog level.
   typedef logic [9:0] cao_code_t;
   // Writable control fields, most significant first.
   typedef struct packed {
      logic amp_en;     // Amplifier enable.
      logic in_sel;     // Comparator input select.
      logic irq_edge;   // Interrupt edge select.
      logic fault_pol;  // Fault polarity select.
      logic cmp_en;     // Comparator enable.
   } cao_ctrl_s;
   // Analog levels seen by the block.
   typedef struct packed {
      cao_code_t port_a_candidate_pin;
      cao_code_t port_b_candidate_pin;
      cao_code_t comparator_minus_pin;
      cao_code_t amplifier_plus_pin;
      cao_code_t amplifier_minus_pin;
   } cao_analog_s;
endpackage : cao_pkg

//--- verilog/cao_top.sv
// Purpose: Control register, comparator and amplifier logic with APB access.
// Assumes: One 40 MHz clock; all inputs synchronous to it.
// Notes: Analog parts are modelled on sampled codes.
//
// Design decision made here: the APB slave port.
`timescale 1ns/10ps
`include "cao_map.svh"

module cao_top (
   input  wire logic               sys_clk_in,
   input  wire logic               rst_b_in,
   input  wire logic               psel_in,
   input  wire logic               penable_in,
   input  wire logic               pwrite_in,
   input  wire logic [11:0]        paddr_in,
   input  wire logic [31:0]        pwdata_in,
   output logic      [31:0]        prdata_out,
   output logic                    pready_out,
   output logic                    pslverr_out,
   input  wire cao_pkg::cao_analog_s analog_in,
   input  wire logic               schmitt_enable_in,
   input  wire logic               port_b3_irq_enable_in,
   output logic                    comparator_irq_out,
   output logic                    pwm_fault_out,
   output logic                    amplifier_output_pin_out,
   output logic                    amplifier_output_pin_oe_out,
   output logic                    port3_data_out,
   output logic                    port_b3_irq_out,
   output logic      [9:0]         converter_channel_three_out
);
   import cao_pkg::*;

   // Returns one when the first level lies strictly above the second.
   function automatic logic above(input cao_code_t a, input cao_code_t b);
      above = (a > b);
   endfunction : above

   cao_ctrl_s  ctrl;          // Writable control fields.
   cao_ctrl_s  next_ctrl;     // Next control fields.
   logic       cmp_out;       // Registered comparator logic output.
   logic       next_cmp_out;  // Next comparator output.
   logic       cmp_irq;       // Registered comparator interrupt pulse.
   logic       next_cmp_irq;  // Next comparator interrupt pulse.
   logic       fault;         // Registered fault level.
   logic       next_fault;    // Next fault level.
   logic       amp_lvl;       // Registered amplifier logic level.
   logic       next_amp_lvl;  // Next amplifier logic level.
   logic       b3_irq;        // Registered port B3 interrupt pulse.
   logic       next_b3_irq;   // Next port B3 interrupt pulse.
   cao_code_t  ch3;           // Registered converter channel three level.
   cao_code_t  next_ch3;      // Next converter channel three level.
   logic [31:0] rdata;        // Read data captured in the setup cycle.
   logic [31:0] next_rdata;   // Next read data.
   cao_code_t  cmp_plus;      // Selected comparator plus level.
   logic       hit;           // Address selects the control register.
   logic       wr_acc;        // Write access phase to the register.
   logic [15:0] amp_diff;     // Amplifier difference, zero when plus is not above minus.

   // Address decode; the slave never waits, so every access ends at once.
   always_comb begin
      if (paddr_in == `CAO_CTRL_ADDR) begin
         hit = 1'b1;
      end else begin
         hit = 1'b0;
      end
   end

   assign wr_acc      = psel_in & penable_in & pwrite_in & hit;
   assign pready_out  = 1'b1;
   // Unmapped addresses answer with an error and read as zero.
   assign pslverr_out = psel_in & penable_in & ~hit;

   // Pin routing for the comparator plus input.
   always_comb begin
      if (ctrl.in_sel) begin
         cmp_plus = analog_in.port_b_candidate_pin;
      end else begin
         cmp_plus = analog_in.port_a_candidate_pin;
      end
   end

   // Control register next state; only software writes change it.
   always_comb begin
      next_ctrl = ctrl;
      if (wr_acc) begin
         // Reserved bits 6 and 5 and the read-only bit 1 are dropped.
         next_ctrl.amp_en    = pwdata_in[`CAO_BIT_AMP_EN];
         next_ctrl.in_sel    = pwdata_in[`CAO_BIT_IN_SEL];
         next_ctrl.irq_edge  = pwdata_in[`CAO_BIT_IRQ_EDGE];
         next_ctrl.fault_pol = pwdata_in[`CAO_BIT_FAULT_POL];
         next_ctrl.cmp_en    = pwdata_in[`CAO_BIT_CMP_EN];
      end
   end

   // Comparator, fault and interrupt next state.
   always_comb begin
      // A disabled comparator holds its last value so no false edge appears.
      if (ctrl.cmp_en) begin
         next_cmp_out = above(cmp_plus, analog_in.comparator_minus_pin);
      end else begin
         next_cmp_out = cmp_out;
      end
      // Rising edge requests when the select is 0, falling edge when 1.
      if (ctrl.irq_edge) begin
         next_cmp_irq = ctrl.cmp_en & cmp_out & ~next_cmp_out;
      end else begin
         next_cmp_irq = ctrl.cmp_en & ~cmp_out & next_cmp_out;
      end
      if (!ctrl.cmp_en) begin
         next_fault = 1'b0;
      end else if (ctrl.fault_pol) begin
         next_fault = above(cmp_plus, analog_in.comparator_minus_pin);
      end else begin
         next_fault = above(analog_in.comparator_minus_pin, cmp_plus);
      end
   end

   // Amplifier difference, unscaled, clamped to zero when the plus level is not above the minus level.
   always_comb begin
      if (analog_in.amplifier_plus_pin > analog_in.amplifier_minus_pin) begin
         amp_diff = 16'(analog_in.amplifier_plus_pin - analog_in.amplifier_minus_pin);
      end else begin
         amp_diff = 16'h0000;
      end
   end

   // Amplifier next state: level, port B3 request and converter feed.
   // The enable is taken from the next control value. That way the level and the
   // converter feed drop at the same edge as the bit, and show no stale level.
   always_comb begin
      if (next_ctrl.amp_en) begin
         next_amp_lvl = above(analog_in.amplifier_plus_pin,
                              analog_in.amplifier_minus_pin);
         // Any positive difference times the gain swings to full scale.
         if (amp_diff != 16'h0000) begin
            next_ch3 = `CAO_CODE_MAX;
         end else begin
            next_ch3 = 10'h000;
         end
      end else begin
         next_amp_lvl = 1'b0;
         next_ch3     = 10'h000;
      end
      // The port pin interrupt fires on each change of the output level while port_b3_irq_enable_in is set and the amplifier stays enabled.
      next_b3_irq = port_b3_irq_enable_in & next_ctrl.amp_en &
                    (next_amp_lvl != amp_lvl);
   end

   // Read data is captured in the setup cycle and held for the access.
   always_comb begin
      next_rdata = rdata;
      if (psel_in && !penable_in) begin
         next_rdata = 32'h0000_0000;
         if (hit) begin
            next_rdata[`CAO_BIT_AMP_EN]    = ctrl.amp_en;
            next_rdata[`CAO_BIT_IN_SEL]    = ctrl.in_sel;
            next_rdata[`CAO_BIT_IRQ_EDGE]  = ctrl.irq_edge;
            next_rdata[`CAO_BIT_FAULT_POL] = ctrl.fault_pol;
            next_rdata[`CAO_BIT_CMP_OUT]   = cmp_out;
            next_rdata[`CAO_BIT_CMP_EN]    = ctrl.cmp_en;
         end
      end
   end

   // Registers only; all values start from constants.
   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         ctrl    <= cao_ctrl_s'(5'(`CAO_CTRL_RESET));
         cmp_out <= 1'b0;
         cmp_irq <= 1'b0;
         fault   <= 1'b0;
         amp_lvl <= 1'b0;
         b3_irq  <= 1'b0;
         ch3     <= 10'h000;
         rdata   <= 32'h0000_0000;
      end else begin
         ctrl    <= next_ctrl;
         cmp_out <= next_cmp_out;
         cmp_irq <= next_cmp_irq;
         fault   <= next_fault;
         amp_lvl <= next_amp_lvl;
         b3_irq  <= next_b3_irq;
         ch3     <= next_ch3;
         rdata   <= next_rdata;
      end
   end

   // Output drive; the amplifier pin is released while disabled.
   assign prdata_out                  = rdata;
   assign comparator_irq_out          = cmp_irq;
   assign pwm_fault_out               = fault;
   assign amplifier_output_pin_out    = amp_lvl;
   assign amplifier_output_pin_oe_out = ctrl.amp_en;
   assign port3_data_out              = amp_lvl & schmitt_enable_in;
   assign port_b3_irq_out             = b3_irq;
   assign converter_channel_three_out = ch3;

   // Checks on the block's own outputs.
   default clocking cb @(posedge sys_clk_in);
   endclocking
   default disable iff (!rst_b_in);

   sequence s_write(bit [7:0] v);
      psel_in && penable_in && pwrite_in && hit && pwdata_in[7:0] == v;
   endsequence

   sequence s_rise;
      !cmp_out ##1 cmp_out;
   endsequence

   sequence s_fall;
      cmp_out ##1 !cmp_out;
   endsequence

   a_cmp_follows_in: assert property (
      ctrl.cmp_en |=> cmp_out == $past(above(cmp_plus, analog_in.comparator_minus_pin)))
      else $error("comparator output does not follow inputs");
   a_cmp_holds_off: assert property (
      !ctrl.cmp_en |=> $stable(cmp_out))
      else $error("disabled comparator output changed");
   a_cmp_stays_on: assert property (
      ctrl.cmp_en && !wr_acc |=> ctrl.cmp_en)
      else $error("comparator disabled without a write");
   a_amp_enable_write: assert property (
      s_write(8'h80) |=> ctrl.amp_en ##0 amplifier_output_pin_oe_out)
      else $error("amplifier enable write not taken");
   a_amp_released_off: assert property (
      !ctrl.amp_en |-> !amplifier_output_pin_oe_out && converter_channel_three_out == 10'h000)
      else $error("disabled amplifier still drives");
   a_irq_rise: assert property (
      ctrl.cmp_en && !ctrl.irq_edge && $past(ctrl.cmp_en) ##0 s_rise |-> cmp_irq)
      else $error("rising edge request missing");
   a_irq_edge_sel: assert property (
      cmp_irq |-> ($past(ctrl.irq_edge) ? $fell(cmp_out) : $rose(cmp_out)))
      else $error("request on wrong edge");
   a_sel_route: assert property (
      s_write(8'h11) |=> ctrl.in_sel && cmp_plus == analog_in.port_b_candidate_pin)
      else $error("input select not routed");
   a_fault_pol: assert property (
      ctrl.cmp_en && ctrl.fault_pol |=>
         fault == $past(above(cmp_plus, analog_in.comparator_minus_pin)))
      else $error("fault polarity wrong");
   a_read_out_bit: assert property (
      psel_in && !penable_in && hit |=> prdata_out[1] == $past(cmp_out))
      else $error("output bit not read back");
   a_port3_level: assert property (
      port3_data_out |-> ctrl.amp_en && schmitt_enable_in && amp_lvl)
      else $error("port 3 level wrong");
   a_b3_irq: assert property (
      b3_irq |-> ctrl.amp_en && $changed(amp_lvl))
      else $error("port B3 request without change");
   a_ch3_feed: assert property (
      ctrl.amp_en && $past(ctrl.amp_en) |-> (converter_channel_three_out != 10'h000) == amp_lvl)
      else $error("channel three disagrees with level");
   a_reserved_zero: assert property (
      psel_in && penable_in && !pwrite_in |-> prdata_out[6:5] == 2'b00 && prdata_out[31:8] == 24'h0)
      else $error("reserved bits not zero");
   a_irq_fall: assert property (
      ctrl.cmp_en && ctrl.irq_edge ##0 s_fall |-> cmp_irq)
      else $error("falling edge request missing");
   a_irq_off_quiet: assert property (
      !ctrl.cmp_en |=> !cmp_irq)
      else $error("disabled comparator raised a request");
   a_fault_pol_low: assert property (
      ctrl.cmp_en && !ctrl.fault_pol |=>
         fault == $past(above(analog_in.comparator_minus_pin, cmp_plus)))
      else $error("fault polarity zero wrong");
   a_fault_idle: assert property (
      !ctrl.cmp_en |=> !fault)
      else $error("fault raised while comparator disabled");
   a_amp_follows_in: assert property (
      ctrl.amp_en && !wr_acc |=>
         amp_lvl == $past(above(analog_in.amplifier_plus_pin, analog_in.amplifier_minus_pin)))
      else $error("amplifier level does not follow inputs");
   a_amp_off_low: assert property (
      !ctrl.amp_en |-> !amp_lvl && !port_b3_irq_out)
      else $error("disabled amplifier shows a level");
   a_b3_irq_raise: assert property (
      port_b3_irq_enable_in && ctrl.amp_en && !wr_acc &&
         (above(analog_in.amplifier_plus_pin, analog_in.amplifier_minus_pin) != amp_lvl)
         |=> b3_irq)
      else $error("port B3 request missing");
   a_sel_port_a: assert property (
      ctrl.cmp_en && !ctrl.in_sel |=>
         cmp_out == $past(above(analog_in.port_a_candidate_pin, analog_in.comparator_minus_pin)))
      else $error("port A pin not compared");
   a_ctrl_write: assert property (
      wr_acc |=> ctrl == $past({pwdata_in[7], pwdata_in[4:2], pwdata_in[0]}))
      else $error("control write not taken");

endmodule : cao_top

//--- bench/cao_analog_model.sv
// Purpose: Model of the analog pins that feed the comparator and amplifier.
// Assumes: Levels arrive as sampled codes, one new set per clock edge.
// Notes: Pins behave as if their alternate functions were already enabled.
`timescale 1ns/10ps
module cao_analog_model (
   input  wire logic                 sys_clk_in,  // System clock.
   input  wire cao_pkg::cao_analog_s level_req_in, // Levels asked for by the bench.
   output cao_pkg::cao_analog_s      analog_out    // Levels seen at the pins.
);
   import cao_pkg::*;
   // The pins settle one edge after a request, so the block never sees a level
   // before a real input stage could have delivered it.
   always_ff @(posedge sys_clk_in) begin
      analog_out <= level_req_in;
   end
endmodule : cao_analog_model

//--- bench/tb.sv
// Purpose: Self-checking bench for the comparator and amplifier control block.
// Assumes: Zero-wait APB slave; analog levels come through the partner model.
// Notes: Reads are queued by the driver and compared by the monitor.
`timescale 1ns/10ps
module tb;
   import cao_pkg::*;
   logic        sys_clk_in, rst_b_in, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic        schmitt, b3_en, cmp_irq, fault, amp_pin, amp_oe, p3, b3_irq;
   logic [9:0]  ch3, m, n;              // Converter output and random analog codes.
   logic        sel, edg, pol, lvl, prev; // Scenario fields.
   cao_analog_s lv, analog;             // Requested and delivered levels.
   logic [32:0] rd_q[$];                // Expected {pslverr, prdata} per read.
   int          miscompares, num_checks, cmp_irqs, b3_irqs, seed;

   cao_analog_model i_cao_analog_model (.sys_clk_in(sys_clk_in), .level_req_in(lv),
      .analog_out(analog));
   cao_top i_cao_top (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in), .psel_in(psel),
      .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
      .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
      .analog_in(analog), .schmitt_enable_in(schmitt), .port_b3_irq_enable_in(b3_en),
      .comparator_irq_out(cmp_irq), .pwm_fault_out(fault),
      .amplifier_output_pin_out(amp_pin), .amplifier_output_pin_oe_out(amp_oe),
      .port3_data_out(p3), .port_b3_irq_out(b3_irq), .converter_channel_three_out(ch3));

   initial begin
      sys_clk_in = 1'b0;
      forever #12.5 sys_clk_in = ~sys_clk_in;
   end

   task automatic check(input string nm, input logic [32:0] seen, input logic [32:0] exp);
      num_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check

   task automatic end_sim();
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : end_sim

   // One APB transfer; a read notes its expected answer for the monitor.
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      input logic [32:0] exp);
      int k;
      @(posedge sys_clk_in);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      if (!wr) rd_q.push_back(exp);
      @(posedge sys_clk_in);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge sys_clk_in);
         k++;
      end while (pready !== 1'b1 && k < 20);
      if (k >= 20) begin
         miscompares++;
         end_sim();
      end else begin
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask : apb

   // Apply a level set and wait until both the pins and the block have settled.
   task automatic drive(input cao_analog_s v);
      cmp_irqs = 0;
      b3_irqs = 0;
      @(posedge sys_clk_in);
      lv <= v;
      repeat (4) @(posedge sys_clk_in);
      @(negedge sys_clk_in);
   endtask : drive

   // The monitor counts request pulses and matches each read against its note.
   always @(posedge sys_clk_in) begin
      if (cmp_irq === 1'b1) cmp_irqs++;
      if (b3_irq === 1'b1) b3_irqs++;
      if (psel && penable && pready === 1'b1 && !pwrite && rd_q.size() > 0)
         check("prdata", {pslverr, prdata}, rd_q.pop_front());
   end

   initial begin
      seed = 32'h3f5e;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      lv = '0;
      schmitt = 1'b0;
      b3_en = 1'b1;
      rst_b_in = 1'b0;
      repeat (12) @(posedge sys_clk_in);
      rst_b_in <= 1'b1;
      apb(1'b0, 12'hf90, '0, 33'h0_0000_0000);
      check("amp_oe", amp_oe, 0);
      apb(1'b1, 12'hf90, 32'hffff_ffff, '0);
      apb(1'b1, 12'hf94, 32'h0000_0000, '0);
      apb(1'b0, 12'hf94, '0, 33'h1_0000_0000);
      apb(1'b0, 12'hf90, '0, 33'h0_0000_009d);
      $display("test registers done");
      for (int i = 0; i < 4; i++) begin
         {sel, edg} = 2'(i);
         pol = 1'($random(seed));
         m = 10'h100 + 10'($random(seed) & 255);
         drive({10'h0, 10'h0, 10'h3ff, 10'h0, 10'h0});
         apb(1'b1, 12'hf90, {27'h0, sel, edg, pol, 2'b01}, '0);
         drive({sel ? 10'h0 : m + 10'h1, sel ? m + 10'h1 : 10'h0, m, 10'h0, 10'h0});
         check("cmp_irq", cmp_irqs, edg ? 0 : 1);
         check("fault", fault, pol);
         apb(1'b0, 12'hf90, '0, {28'h0, sel, edg, pol, 2'b11});
         drive({sel ? 10'h3ff : m, sel ? m : 10'h3ff, m, 10'h0, 10'h0});
         check("cmp_irq", cmp_irqs, edg ? 1 : 0);
         check("fault", fault, 0);
         apb(1'b0, 12'hf90, '0, {28'h0, sel, edg, pol, 2'b01});
      end
      $display("test comparator done");
      apb(1'b1, 12'hf90, 32'h0000_0001, '0);
      drive({m + 10'h1, 10'h0, m, 10'h0, 10'h0});
      apb(1'b1, 12'hf90, 32'h0000_0000, '0);
      drive({10'h0, 10'h0, m, 10'h0, 10'h0});
      check("cmp_irq", cmp_irqs, 0);
      apb(1'b0, 12'hf90, '0, 33'h0_0000_0002);
      $display("test disable done");
      apb(1'b1, 12'hf90, 32'h0000_0080, '0);
      prev = 1'b0;
      for (int i = 0; i < 8; i++) begin
         @(posedge sys_clk_in);
         schmitt <= 1'($random(seed));
         b3_en <= 1'($random(seed));
         m = 10'($random(seed));
         n = 10'($random(seed));
         lvl = m > n;
         drive({10'h0, 10'h0, 10'h0, m, n});
         check("amp_pin", amp_pin, lvl);
         check("amp_oe", amp_oe, 1);
         check("ch3", ch3, {10{lvl}});
         check("port3", p3, lvl & schmitt);
         check("b3_irq", b3_irqs, (lvl != prev) && b3_en);
         prev = lvl;
      end
      apb(1'b1, 12'hf90, 32'h0000_0000, '0);
      drive({10'h0, 10'h0, 10'h0, 10'h3ff, 10'h0});
      check("amp_oe", amp_oe, 0);
      check("ch3", ch3, 0);
      $display("test amplifier done");
      end_sim();
   end
endmodule : tb
